// >>> bcht_defs.svh
`ifndef BCHT_DEFS_SVH
`define BCHT_DEFS_SVH

// Dword-aligned byte addresses of the three words this block owns
`define BCHT_OFF_IO_HIGH 8'h30
`define BCHT_OFF_CAP_PTR 8'h34
`define BCHT_OFF_INT_BCTL 8'h3C

// Byte offsets of the individual registers
`define BCHT_OFF_IO_BASE_HIGH 8'h30
`define BCHT_OFF_IO_LIMIT_HIGH 8'h32
`define BCHT_OFF_INT_LINE 8'h3C
`define BCHT_OFF_INT_PIN 8'h3D
`define BCHT_OFF_BCTL 8'h3E

// Reset and fixed values
`define BCHT_RST_IO_BASE_HIGH 16'h0000
`define BCHT_RST_IO_LIMIT_HIGH 16'h0000
`define BCHT_VAL_CAP_PTR 8'h40
`define BCHT_RST_INT_LINE 8'hFF
`define BCHT_VAL_INT_PIN 8'h00
`define BCHT_VAL_BCTL_RSVD 4'h0

// Bridge control field positions
`define BCHT_BCTL_MSG_EN_BIT 11
`define BCHT_BCTL_FLAG_BIT 10
`define BCHT_BCTL_PERIOD_BIT 9
`define BCHT_BCTL_RSVD_HI 15
`define BCHT_BCTL_RSVD_LO 12

// Composed I/O window low address fill
`define BCHT_IO_BASE_FILL 20'h00000
`define BCHT_IO_LIMIT_FILL 20'hFFFFF

`endif

// >>> bcht_pkg.sv
`default_nettype none
package bcht_pkg;

  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bcht_cfg_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } bcht_cfg_rsp_s;

  typedef struct packed {
    logic valid;
    logic fatal;
  } bcht_err_msg_s;

endpackage
`default_nettype wire

// >>> bcht_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module bcht_sync2 #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule
`default_nettype wire

// >>> bcht_io_window.sv
`timescale 1ns/100ps
`default_nettype none
`include "bcht_defs.svh"
module bcht_io_window (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [15:0] base_high_i,
  input wire logic [15:0] limit_high_i,
  input wire logic io_valid_i,
  input wire logic [31:0] io_addr_i,
  output logic io_fwd_o
);

  logic [31:0] base_full;
  logic [31:0] limit_full;
  logic hit;
  logic fwd_ff;

  // Only the low 12 field bits fit a 32-bit address
  assign base_full = {base_high_i[11:0], `BCHT_IO_BASE_FILL};
  assign limit_full = {limit_high_i[11:0], `BCHT_IO_LIMIT_FILL};
  assign hit = (io_addr_i >= base_full) && (io_addr_i <= limit_full);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      fwd_ff <= 1'b0;
    else
      fwd_ff <= io_valid_i && hit;
  end

  assign io_fwd_o = fwd_ff;

  property p_fwd_inside;
    @(posedge clk_i) disable iff (reset_i)
    io_fwd_o |-> ($past(io_addr_i)
      >= {$past(base_high_i[11:0]), `BCHT_IO_BASE_FILL})
      && ($past(io_addr_i)
      <= {$past(limit_high_i[11:0]), `BCHT_IO_LIMIT_FILL})
      && $past(io_valid_i);
  endproperty
  a_fwd_inside: assert property (p_fwd_inside)
    else $error("I/O forward outside window");

endmodule
`default_nettype wire

// >>> bcht_cfg_tail.sv
// Functional notes
// - I/O window base upper field, 16-bit RW, reset zero, low bits zero.
// - I/O window limit upper field, 16-bit RW, reset zero, low bits ones.
// - Capability pointer byte reads fixed 40h, read-only.
// - Interrupt line byte RW, resets FFh, pure scratch storage.
// - Interrupt pin byte reads 00h; writes ignored.
// - Secondary interrupts are forwarded to the primary side.
// - Bridge control bits 15:12 reserved, always read zero.
// - Bit 11 set: discard expiry sends error message on primary side.
// - Bit 11 effective only in conventional PCI secondary mode.
// - Fatal severity selectable only with error reporting; else nonfatal.
// - Bit 11 clear: message still sent if error reporting and unmasked.
// - Discard expiry deletes delayed transaction and sets status flag.
// - Status flag bit 10 reads 1 after a discard event.
`timescale 1ns/100ps
`default_nettype none
`include "bcht_defs.svh"
module bcht_cfg_tail
  import bcht_pkg::*;
#(
  parameter bit AER_SUPPORTED = 1'b1,
  parameter int INTX_W = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire bcht_cfg_req_s cfg_req_i,
  output bcht_cfg_rsp_s cfg_rsp_o,
  input wire logic [8:0] bctl_low_i,
  input wire logic io_valid_i,
  input wire logic [31:0] io_addr_i,
  output logic io_fwd_o,
  input wire logic [INTX_W-1:0] sec_intx_i,
  output logic [INTX_W-1:0] pri_intx_o,
  input wire logic discard_expire_i,
  input wire logic conventional_mode_i,
  input wire logic aer_discard_mask_i,
  input wire logic aer_severity_fatal_i,
  output logic dtx_delete_o,
  output bcht_err_msg_s err_msg_o,
  output logic secondary_discard_period_select_o,
  output logic [15:0] io_window_base_high_o,
  output logic [15:0] io_window_limit_high_o
);

  logic [15:0] io_window_base_high_field_ff;
  logic [15:0] io_window_limit_high_field_ff;
  logic [7:0] interrupt_line_scratch_ff;
  logic discard_expiry_msg_enable_ff;
  logic discard_expiry_flag_ff;
  logic secondary_discard_period_select_ff;
  logic dtx_delete_ff;
  bcht_err_msg_s err_msg_ff;
  bcht_cfg_rsp_s rsp_ff;
  logic wr_io;
  logic wr_int;
  logic hit;
  logic flag_clear;
  logic msg_send;

  function automatic logic decode_hit(input logic [7:0] addr);
    decode_hit = (addr == `BCHT_OFF_IO_HIGH) || (addr == `BCHT_OFF_CAP_PTR)
      || (addr == `BCHT_OFF_INT_BCTL);
  endfunction

  function automatic logic [15:0] bctl_word(input logic msg_en,
    input logic flag, input logic period, input logic [8:0] low);
    bctl_word = {`BCHT_VAL_BCTL_RSVD, msg_en, flag, period, low};
  endfunction

  assign hit = decode_hit(cfg_req_i.addr);
  assign wr_io = cfg_req_i.req && cfg_req_i.we
    && (cfg_req_i.addr == `BCHT_OFF_IO_HIGH);
  assign wr_int = cfg_req_i.req && cfg_req_i.we
    && (cfg_req_i.addr == `BCHT_OFF_INT_BCTL);

  // Window fields, byte lanes honoured
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      io_window_base_high_field_ff <= `BCHT_RST_IO_BASE_HIGH;
      io_window_limit_high_field_ff <= `BCHT_RST_IO_LIMIT_HIGH;
    end
    else if (wr_io)
    begin
      if (cfg_req_i.be[0])
        io_window_base_high_field_ff[7:0] <= cfg_req_i.wdata[7:0];
      if (cfg_req_i.be[1])
        io_window_base_high_field_ff[15:8] <= cfg_req_i.wdata[15:8];
      if (cfg_req_i.be[2])
        io_window_limit_high_field_ff[7:0] <= cfg_req_i.wdata[23:16];
      if (cfg_req_i.be[3])
        io_window_limit_high_field_ff[15:8] <= cfg_req_i.wdata[31:24];
    end
  end

  // Scratch only; nothing in the bridge reads it
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      interrupt_line_scratch_ff <= `BCHT_RST_INT_LINE;
    else if (wr_int && cfg_req_i.be[0])
      interrupt_line_scratch_ff <= cfg_req_i.wdata[7:0];
  end

  // Pin byte (lane 1) and reserved bits have no storage at all
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      discard_expiry_msg_enable_ff <= 1'b0;
      secondary_discard_period_select_ff <= 1'b0;
    end
    else if (wr_int && cfg_req_i.be[3])
    begin
      discard_expiry_msg_enable_ff <=
        cfg_req_i.wdata[16 + `BCHT_BCTL_MSG_EN_BIT];
      secondary_discard_period_select_ff <=
        cfg_req_i.wdata[16 + `BCHT_BCTL_PERIOD_BIT];
    end
  end

  // Write one to clear; a new expiry in the same cycle wins
  assign flag_clear = wr_int && cfg_req_i.be[3]
    && cfg_req_i.wdata[16 + `BCHT_BCTL_FLAG_BIT];

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      discard_expiry_flag_ff <= 1'b0;
    else if (discard_expire_i)
      discard_expiry_flag_ff <= 1'b1;
    else if (flag_clear)
      discard_expiry_flag_ff <= 1'b0;
  end

  // Discard queue delete strobe
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      dtx_delete_ff <= 1'b0;
    else
      dtx_delete_ff <= discard_expire_i;
  end

  // Error message path
  assign msg_send = discard_expire_i && conventional_mode_i
    && (discard_expiry_msg_enable_ff
      || (AER_SUPPORTED && !aer_discard_mask_i));

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      err_msg_ff <= '0;
    else
    begin
      err_msg_ff.valid <= msg_send;
      err_msg_ff.fatal <= msg_send && AER_SUPPORTED
        && aer_severity_fatal_i;
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rsp_ff <= '0;
    else
    begin
      rsp_ff.ack <= cfg_req_i.req && hit;
      if (cfg_req_i.req && !cfg_req_i.we)
      begin
        unique case (cfg_req_i.addr)
          `BCHT_OFF_IO_HIGH:
            rsp_ff.rdata <= {io_window_limit_high_field_ff,
              io_window_base_high_field_ff};
          `BCHT_OFF_CAP_PTR:
            rsp_ff.rdata <= {24'h000000, `BCHT_VAL_CAP_PTR};
          `BCHT_OFF_INT_BCTL:
            rsp_ff.rdata <= {bctl_word(discard_expiry_msg_enable_ff,
              discard_expiry_flag_ff, secondary_discard_period_select_ff,
              bctl_low_i), `BCHT_VAL_INT_PIN,
              interrupt_line_scratch_ff};
          default:
            rsp_ff.rdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign cfg_rsp_o = rsp_ff;
  assign dtx_delete_o = dtx_delete_ff;
  assign err_msg_o = err_msg_ff;
  assign secondary_discard_period_select_o =
    secondary_discard_period_select_ff;
  assign io_window_base_high_o = io_window_base_high_field_ff;
  assign io_window_limit_high_o = io_window_limit_high_field_ff;

  // Interrupt wires cross in from the secondary pins
  bcht_sync2 #(
    .W(INTX_W)
  ) u_intx_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(sec_intx_i),
    .sync_o(pri_intx_o)
  );

  bcht_io_window u_io_window (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .base_high_i(io_window_base_high_field_ff),
    .limit_high_i(io_window_limit_high_field_ff),
    .io_valid_i(io_valid_i),
    .io_addr_i(io_addr_i),
    .io_fwd_o(io_fwd_o)
  );

  property p_base_write;
    @(posedge clk_i) disable iff (reset_i)
    (wr_io && cfg_req_i.be[1:0] == 2'b11)
      |=> io_window_base_high_o == $past(cfg_req_i.wdata[15:0]);
  endproperty
  a_base_write: assert property (p_base_write)
    else $error("Base field did not take written value");

  property p_limit_write;
    @(posedge clk_i) disable iff (reset_i)
    (wr_io && cfg_req_i.be[3:2] == 2'b11)
      |=> io_window_limit_high_o == $past(cfg_req_i.wdata[31:16]);
  endproperty
  a_limit_write: assert property (p_limit_write)
    else $error("Limit field did not take written value");

  property p_cap_read;
    @(posedge clk_i) disable iff (reset_i)
    (cfg_req_i.req && !cfg_req_i.we && cfg_req_i.addr == `BCHT_OFF_CAP_PTR)
      |=> cfg_rsp_o.ack
        && cfg_rsp_o.rdata == {24'h000000, `BCHT_VAL_CAP_PTR};
  endproperty
  a_cap_read: assert property (p_cap_read)
    else $error("Capability pointer read wrong");

  property p_line_reset;
    @(posedge clk_i)
    $past(reset_i) && !reset_i
      |-> interrupt_line_scratch_ff == `BCHT_RST_INT_LINE;
  endproperty
  a_line_reset: assert property (p_line_reset)
    else $error("Interrupt line not FFh after reset");

  property p_pin_rsvd_read;
    @(posedge clk_i) disable iff (reset_i)
    (cfg_req_i.req && !cfg_req_i.we && cfg_req_i.addr == `BCHT_OFF_INT_BCTL)
      |=> cfg_rsp_o.rdata[15:8] == `BCHT_VAL_INT_PIN
        && cfg_rsp_o.rdata[31:28] == `BCHT_VAL_BCTL_RSVD;
  endproperty
  a_pin_rsvd_read: assert property (p_pin_rsvd_read)
    else $error("Pin byte or reserved bits not zero");

  property p_intx_fwd;
    @(posedge clk_i) disable iff (reset_i)
    !$past(reset_i) && !$past(reset_i, 2)
      |-> pri_intx_o == $past(sec_intx_i, 2);
  endproperty
  a_intx_fwd: assert property (p_intx_fwd)
    else $error("Secondary interrupt not forwarded in two cycles");

  property p_msg_enabled;
    @(posedge clk_i) disable iff (reset_i)
    (discard_expire_i && conventional_mode_i && discard_expiry_msg_enable_ff)
      |=> err_msg_o.valid;
  endproperty
  a_msg_enabled: assert property (p_msg_enabled)
    else $error("Enabled discard expiry sent no message");

  property p_msg_mode;
    @(posedge clk_i) disable iff (reset_i)
    err_msg_o.valid |-> $past(conventional_mode_i) && $past(discard_expire_i);
  endproperty
  a_msg_mode: assert property (p_msg_mode)
    else $error("Message outside conventional mode or without expiry");

  property p_severity;
    @(posedge clk_i) disable iff (reset_i)
    err_msg_o.fatal |-> err_msg_o.valid && AER_SUPPORTED;
  endproperty
  a_severity: assert property (p_severity)
    else $error("Fatal severity without error reporting");

  property p_unmasked;
    @(posedge clk_i) disable iff (reset_i)
    (discard_expire_i && conventional_mode_i && !discard_expiry_msg_enable_ff
      && AER_SUPPORTED && !aer_discard_mask_i) |=> err_msg_o.valid;
  endproperty
  a_unmasked: assert property (p_unmasked)
    else $error("Unmasked discard expiry sent no message");

  property p_flag_set;
    @(posedge clk_i) disable iff (reset_i)
    discard_expire_i |=> discard_expiry_flag_ff && dtx_delete_o;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Discard expiry did not set flag and delete");

endmodule
`default_nettype wire

// >>> bcht_cfg_host.sv
`timescale 1ns/100ps
`default_nettype none
module bcht_cfg_host
  import bcht_pkg::*;
(
  input wire logic clk_i,
  output bcht_cfg_req_s cfg_req_o,
  input wire bcht_cfg_rsp_s cfg_rsp_i
);

  initial cfg_req_o = '0;

  // One access, then one idle cycle so ack can be seen to drop again
  task automatic access(input logic we, input logic [7:0] a,
                        input logic [3:0] be, input logic [31:0] wd,
                        output logic ack, output logic [31:0] rd);
    cfg_req_o = '{req: 1'b1, we: we, addr: a, be: be, wdata: wd};
    @(posedge clk_i);
    #1;
    ack = cfg_rsp_i.ack;
    rd = cfg_rsp_i.rdata;
    // Released fields flip so a stale value never looks live
    cfg_req_o = '{req: 1'b0, we: ~we, addr: ~a, be: ~be, wdata: ~wd};
    @(posedge clk_i);
    #1;
    if (cfg_rsp_i.ack !== 1'b0)
    begin
      ack = 1'bx;
    end
  endtask

endmodule
`default_nettype wire

// >>> tb_bridge_cfg_header_tail_regs.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb_bridge_cfg_header_tail_regs;
  import bcht_pkg::*;

  localparam logic [8:0] LOW = 9'h1A5;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  bcht_cfg_req_s cfg_req;
  bcht_cfg_rsp_s cfg_rsp;
  bcht_err_msg_s err_msg;
  logic io_valid = 1'b0;
  logic [31:0] io_addr = 32'h0000_0000;
  logic io_fwd;
  logic [3:0] sec_intx = 4'h0;
  logic [3:0] pri_intx;
  logic expire = 1'b0;
  logic conv = 1'b0;
  logic mask = 1'b0;
  logic sev = 1'b0;
  logic dtx_delete;
  logic period;
  logic [15:0] base_o;
  logic [15:0] limit_o;
  logic ack;
  logic [31:0] rd;
  int num_errors = 0;
  int comparisons = 0;

  always #25 clk_i = ~clk_i;

  bcht_cfg_tail DUT (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .cfg_req_i(cfg_req),
    .cfg_rsp_o(cfg_rsp),
    .bctl_low_i(LOW),
    .io_valid_i(io_valid),
    .io_addr_i(io_addr),
    .io_fwd_o(io_fwd),
    .sec_intx_i(sec_intx),
    .pri_intx_o(pri_intx),
    .discard_expire_i(expire),
    .conventional_mode_i(conv),
    .aer_discard_mask_i(mask),
    .aer_severity_fatal_i(sev),
    .dtx_delete_o(dtx_delete),
    .err_msg_o(err_msg),
    .secondary_discard_period_select_o(period),
    .io_window_base_high_o(base_o),
    .io_window_limit_high_o(limit_o)
  );

  bcht_cfg_host host (
    .clk_i(clk_i),
    .cfg_req_o(cfg_req),
    .cfg_rsp_i(cfg_rsp)
  );

  function automatic logic [31:0] exp3c(input logic [7:0] line,
      input logic en, input logic flag, input logic per);
    return {4'h0, en, flag, per, LOW, 8'h00, line};
  endfunction

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    host.access(1'b0, a, 4'hF, 32'h0000_0000, ack, rd);
    `CHK("read ack", 1'b1, ack)
    `CHK("read data", e, rd)
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    host.access(1'b1, a, be, d, ack, rd);
    `CHK("write ack", 1'b1, ack)
  endtask

  task automatic io_chk(input logic [31:0] a, input logic e);
    io_addr = a;
    io_valid = 1'b1;
    @(posedge clk_i);
    #1;
    io_valid = 1'b0;
    io_addr = ~a;
    `CHK("io forward", e, io_fwd)
    // Let an edge pass so back-to-back calls never re-raise valid at once
    @(posedge clk_i);
    #1;
    `CHK("io forward pulse", 1'b0, io_fwd)
  endtask

  // Error reporting is built in, so unmasked expiry reports even with
  // the enable clear
  task automatic dsc(input logic c, input logic m, input logic s,
                     input logic en);
    logic v;
    v = c && (en || !m);
    conv = c;
    mask = m;
    sev = s;
    expire = 1'b1;
    @(posedge clk_i);
    #1;
    expire = 1'b0;
    `CHK("delete", 1'b1, dtx_delete)
    `CHK("msg valid", v, err_msg.valid)
    if (v)
    begin
      `CHK("msg fatal", s, err_msg.fatal)
    end
    @(posedge clk_i);
    #1;
    `CHK("delete pulse", 1'b0, dtx_delete)
    `CHK("msg pulse", 1'b0, err_msg.valid)
  endtask

  task automatic finish_test;
    if (num_errors == 0 && comparisons > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial
  begin
    #100000;
    num_errors++;
    finish_test;
  end

  initial
  begin
    repeat (16) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    rd_chk(8'h30, 32'h0000_0000);
    host.access(1'b0, 8'h34, 4'hF, 32'h0000_0000, ack, rd);
    `CHK("cap ptr", 8'h40, rd[7:0])
    rd_chk(8'h3C, exp3c(8'hFF, 1'b0, 1'b0, 1'b0));
    io_chk(32'h000F_FFFF, 1'b1);
    io_chk(32'h0010_0000, 1'b0);
    wr(8'h30, 4'hF, 32'hF345_A123);
    `CHK("base out", 16'hA123, base_o)
    `CHK("limit out", 16'hF345, limit_o)
    wr(8'h30, 4'h1, 32'hFFFF_FF00);
    rd_chk(8'h30, 32'hF345_A100);
    io_chk(32'h0FFF_FFFF, 1'b0);
    io_chk(32'h1000_0000, 1'b1);
    io_chk(32'h345F_FFFF, 1'b1);
    io_chk(32'h3460_0000, 1'b0);
    wr(8'h34, 4'hF, 32'hFFFF_FFFF);
    host.access(1'b0, 8'h34, 4'hF, 32'h0000_0000, ack, rd);
    `CHK("cap ptr kept", 8'h40, rd[7:0])
    wr(8'h3C, 4'hF, 32'hFFFF_FF5A);
    rd_chk(8'h3C, exp3c(8'h5A, 1'b1, 1'b0, 1'b1));
    `CHK("period out", 1'b1, period)
    host.access(1'b0, 8'h38, 4'hF, 32'h0000_0000, ack, rd);
    `CHK("unmapped ack", 1'b0, ack)
    for (int en = 0; en < 2; en++)
    begin
      // Flag cleared by the same write that sets or clears the enable
      wr(8'h3C, 4'hC, {4'hF, en[0], 1'b1, 1'b0, 9'h000, 16'h0000});
      for (int i = 0; i < 8; i++)
      begin
        dsc(i[2], i[1], i[0], en[0]);
      end
      rd_chk(8'h3C, exp3c(8'h5A, en[0], 1'b1, 1'b0));
    end
    wr(8'h3C, 4'hC, {4'h0, 1'b0, 1'b1, 1'b0, 9'h000, 16'h0000});
    rd_chk(8'h3C, exp3c(8'h5A, 1'b0, 1'b0, 1'b0));
    sec_intx = 4'hA;
    @(posedge clk_i);
    #1;
    `CHK("intx early", 4'h0, pri_intx)
    @(posedge clk_i);
    #1;
    `CHK("intx forward", 4'hA, pri_intx)
    finish_test;
  end

endmodule
`default_nettype wire
